// File: rtl/acs_pkg.sv
// acs_pkg: constants for the converter control and analog select block
// assumes a 32-bit AHB-Lite register bus, one word per register
package acs_pkg;

    // register byte offsets
    localparam logic [7:0] ACS_OFS_CTRL_PRI  = 8'h00;
    localparam logic [7:0] ACS_OFS_CTRL_SEC  = 8'h04;
    localparam logic [7:0] ACS_OFS_ASEL_LOW  = 8'h08;
    localparam logic [7:0] ACS_OFS_ASEL_HIGH = 8'h0c;
    localparam logic [7:0] ACS_OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] ACS_OFS_IRQ_CLR   = 8'h14;
    localparam logic [7:0] ACS_OFS_IRQ_EN    = 8'h18;
    localparam logic [7:0] ACS_OFS_PORT_IN   = 8'h1c;
    localparam logic [7:0] ACS_OFS_RESULT    = 8'h20;

    // primary control field positions
    localparam int ACS_PRI_EN_BIT    = 0;
    localparam int ACS_PRI_GO_BIT    = 1;
    localparam int ACS_PRI_CHS_LSB   = 2;
    localparam int ACS_PRI_CHS_MSB   = 5;
    localparam int ACS_PRI_DIV_LSB   = 6;
    localparam int ACS_PRI_DIV_MSB   = 7;

    // secondary control field positions and writable mask
    localparam int         ACS_SEC_JUST_BIT = 7;
    localparam logic [7:0] ACS_SEC_WMASK    = 8'hb0;

    // reset values
    localparam logic [7:0] ACS_CTRL_PRI_RST = 8'h00;
    localparam logic [7:0] ACS_CTRL_SEC_RST = 8'h00;
    localparam logic [7:0] ACS_ASEL_RST     = 8'hff;

    // channel codes for the two internal references
    localparam logic [3:0] ACS_CHS_COMPARATOR_VOLTAGE_REF    = 4'he;
    localparam logic [3:0] ACS_CHS_FIXREF   = 4'hf;

    // interrupt status bits
    localparam int ACS_IRQ_DONE_BIT   = 0;
    localparam int ACS_IRQ_REFUSE_BIT = 1;
    localparam int ACS_IRQ_W          = 2;

    // conversion clock divider select codes and half periods
    typedef enum logic [1:0] {
        ACS_DIV2, ACS_DIV8, ACS_DIV32, ACS_DIVRC
    } acs_div_t;
    localparam logic [3:0] ACS_HALF_DIV2  = 4'h0; // toggle each cycle
    localparam logic [3:0] ACS_HALF_DIV8  = 4'h3; // toggle every 4
    localparam logic [3:0] ACS_HALF_DIV32 = 4'hf; // toggle every 16

    // ahb transfer type codes
    localparam logic [1:0] ACS_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] ACS_HTRANS_SEQ    = 2'b11;

endpackage

// File: rtl/acs_adc_ctrl.sv
// acs_adc_ctrl: converter control and analog pin select with an ahb slave
// assumes the converter core answers each start with one done pulse and
// that port pin inputs and the internal rc clock are synchronous to sys_clk
//
// Overview of operation
// - four conversion clocks are offered: sys/2, sys/8, sys/32 or rc.
// - the channel select is four bits wide, reaching codes 0 to 15.
// - channel select sits in bits 5..2, divider in 7..6, all rw, zero.
// - each of pins 0..13 is analog or digital by its analog select bit.
// - a set analog select bit turns that pin's digital input buffer off.
// - both analog select registers reset to all ones.
// - bit 1 starts a conversion, stays set while busy, clears at done.
// - codes 0..13 pick inputs, 14 the comparator ref, 15 the fixed ref.
// - an analog pin reads as zero; its output drive is unaffected.
// - bit 7 of the secondary control picks right or left justify.
`timescale 1ns/100ps
`default_nettype none

module acs_adc_ctrl
    import acs_pkg::*;
#(
    parameter int NPINS = 14,                  // analog capable pins
    parameter int RES_W = 10                   // converter result width
) (
    input  wire logic              sys_clk_i,      // system clock 200 MHz
    input  wire logic              reset_n_i,      // async reset, active low
    // ahb-lite slave
    input  wire logic              hsel_i,         // slave select
    input  wire logic [31:0]       haddr_i,        // byte address
    input  wire logic [1:0]        htrans_i,       // transfer type
    input  wire logic              hwrite_i,       // write when high
    input  wire logic [2:0]        hsize_i,        // transfer size
    input  wire logic              hready_i,       // bus ready in
    input  wire logic [31:0]       hwdata_i,       // write data
    output logic      [31:0]       hrdata_o,       // read data
    output logic                   hreadyout_o,    // slave ready
    output logic                   hresp_o,        // always okay
    // converter core
    input  wire logic              rc_clk_i,       // internal rc conv clock
    input  wire logic              conv_done_i,    // conversion done pulse
    input  wire logic [RES_W-1:0]  conv_result_i,  // raw result at done
    output logic                   conv_enable_o,  // core powered
    output logic                   conv_start_o,   // start pulse
    output logic                   conv_clk_o,     // selected conv clock
    output logic      [3:0]        input_channel_sel_o, // channel code
    output logic      [NPINS-1:0]  chan_onehot_o,  // analog mux select
    output logic                   chan_comparator_voltage_ref_o,   // comparator ref picked
    output logic                   chan_fixref_o,  // fixed ref picked
    // port pins
    input  wire logic [NPINS-1:0]  port_pin_i,     // raw pin levels
    output logic      [NPINS-1:0]  input_buf_en_o, // digital buffer enable
    output logic                   irq_o           // level interrupt
);

    // register state
    logic [7:0]           ctrl_pri_r;
    logic [7:0]           ctrl_sec_r;
    logic [7:0]           asel_low_r;
    logic [7:0]           asel_high_r;
    logic [ACS_IRQ_W-1:0] irq_stat_r;
    logic [ACS_IRQ_W-1:0] irq_en_r;
    logic [15:0]          result_r;
    logic [NPINS-1:0]     port_in_r;

    // bus data phase state
    logic                 wr_pend_r;
    logic [7:0]           wr_addr_r;

    // decoded fields
    logic                 conv_en;
    logic                 busy;
    acs_div_t             div_sel;
    logic [3:0]           chs;
    logic [NPINS-1:0]     asel;

    assign conv_en = ctrl_pri_r[ACS_PRI_EN_BIT];
    assign busy    = ctrl_pri_r[ACS_PRI_GO_BIT];
    assign div_sel = acs_div_t'(ctrl_pri_r[ACS_PRI_DIV_MSB:ACS_PRI_DIV_LSB]);
    assign chs     = ctrl_pri_r[ACS_PRI_CHS_MSB:ACS_PRI_CHS_LSB];
    assign asel    = NPINS'({asel_high_r, asel_low_r});

    // address phase qualification
    logic addr_ok;
    logic wr_req;
    logic rd_req;
    assign addr_ok = hsel_i && hready_i &&
                     (htrans_i == ACS_HTRANS_NONSEQ ||
                      htrans_i == ACS_HTRANS_SEQ);
    assign wr_req  = addr_ok && hwrite_i;
    assign rd_req  = addr_ok && !hwrite_i;

    // write strobes in the data phase
    logic wr_pri;
    logic wr_sec;
    logic wr_alo;
    logic wr_ahi;
    logic wr_iclr;
    logic wr_ien;
    assign wr_pri  = wr_pend_r && wr_addr_r == ACS_OFS_CTRL_PRI;
    assign wr_sec  = wr_pend_r && wr_addr_r == ACS_OFS_CTRL_SEC;
    assign wr_alo  = wr_pend_r && wr_addr_r == ACS_OFS_ASEL_LOW;
    assign wr_ahi  = wr_pend_r && wr_addr_r == ACS_OFS_ASEL_HIGH;
    assign wr_iclr = wr_pend_r && wr_addr_r == ACS_OFS_IRQ_CLR;
    assign wr_ien  = wr_pend_r && wr_addr_r == ACS_OFS_IRQ_EN;

    // start request and its refusal when the converter is off
    logic go_wr;
    logic start_ok;
    logic start_refused;
    assign go_wr         = wr_pri && hwdata_i[ACS_PRI_GO_BIT] && !busy;
    assign start_ok      = go_wr && hwdata_i[ACS_PRI_EN_BIT];
    assign start_refused = go_wr && !hwdata_i[ACS_PRI_EN_BIT];

    // bus slave: capture write address, answer with zero wait states
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_pend_r   <= wr_req;
            wr_addr_r   <= wr_req ? {haddr_i[7:2], 2'b00} : 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_req) begin
            case ({haddr_i[7:2], 2'b00})
                ACS_OFS_CTRL_PRI:  hrdata_o <= {24'h000000, ctrl_pri_r};
                ACS_OFS_CTRL_SEC:  hrdata_o <= {24'h000000, ctrl_sec_r};
                ACS_OFS_ASEL_LOW:  hrdata_o <= {24'h000000, asel_low_r};
                ACS_OFS_ASEL_HIGH: hrdata_o <= {24'h000000, asel_high_r};
                ACS_OFS_IRQ_STAT:  hrdata_o <= 32'(irq_stat_r);
                ACS_OFS_IRQ_EN:    hrdata_o <= 32'(irq_en_r);
                ACS_OFS_PORT_IN:   hrdata_o <= 32'(port_in_r);
                ACS_OFS_RESULT:    hrdata_o <= {16'h0000, result_r};
                default:           hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // primary control: fields rw, busy bit set by start, cleared at done
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_pri_r <= ACS_CTRL_PRI_RST;
        end else begin
            if (wr_pri) begin
                ctrl_pri_r[7:2]            <= hwdata_i[7:2];
                ctrl_pri_r[ACS_PRI_EN_BIT] <= hwdata_i[ACS_PRI_EN_BIT];
            end
            if (start_ok) begin
                ctrl_pri_r[ACS_PRI_GO_BIT] <= 1'b1;
            end else if (wr_pri && !hwdata_i[ACS_PRI_GO_BIT]) begin
                ctrl_pri_r[ACS_PRI_GO_BIT] <= 1'b0;       // software abort
            end else if (busy && (conv_done_i || !conv_en)) begin
                ctrl_pri_r[ACS_PRI_GO_BIT] <= 1'b0;
            end
        end
    end

    // secondary control: justify and reference bits, others read zero
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_sec_r <= ACS_CTRL_SEC_RST;
        end else if (wr_sec) begin
            ctrl_sec_r <= hwdata_i[7:0] & ACS_SEC_WMASK;
        end
    end

    // analog select pair, all pins analog after reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            asel_low_r  <= ACS_ASEL_RST;
            asel_high_r <= ACS_ASEL_RST;
        end else begin
            if (wr_alo) begin
                asel_low_r <= hwdata_i[7:0];
            end
            if (wr_ahi) begin
                asel_high_r <= hwdata_i[7:0];
            end
        end
    end

    // per pin: buffer enable and gated port read value
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    input_buf_en_o[gi] <= 1'b0;
                    port_in_r[gi]      <= 1'b0;
                    chan_onehot_o[gi]  <= 1'b0;
                end else begin
                    input_buf_en_o[gi] <= !asel[gi];
                    port_in_r[gi]      <= port_pin_i[gi] && !asel[gi];
                    chan_onehot_o[gi]  <= conv_en && (chs == 4'(gi));
                end
            end
        end
    endgenerate

    // channel decode for the two internal references
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            input_channel_sel_o <= 4'h0;
            chan_comparator_voltage_ref_o        <= 1'b0;
            chan_fixref_o       <= 1'b0;
        end else begin
            input_channel_sel_o <= chs;
            chan_comparator_voltage_ref_o        <= conv_en && chs == ACS_CHS_COMPARATOR_VOLTAGE_REF;
            chan_fixref_o       <= conv_en && chs == ACS_CHS_FIXREF;
        end
    end

    // converter enable and start pulse to the core
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_enable_o <= 1'b0;
            conv_start_o  <= 1'b0;
        end else begin
            conv_enable_o <= wr_pri ? hwdata_i[ACS_PRI_EN_BIT] : conv_en;
            conv_start_o  <= start_ok;
        end
    end

    // conversion clock: sys divided by 2, 8, 32, or the rc clock
    logic [3:0] half_cnt_r;
    logic [3:0] half_lim;
    always_comb begin
        case (div_sel)
            ACS_DIV2:  half_lim = ACS_HALF_DIV2;
            ACS_DIV8:  half_lim = ACS_HALF_DIV8;
            ACS_DIV32: half_lim = ACS_HALF_DIV32;
            default:   half_lim = ACS_HALF_DIV2;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_cnt_r <= 4'h0;
            conv_clk_o <= 1'b0;
        end else if (!conv_en) begin
            half_cnt_r <= 4'h0;                    // idle while disabled
            conv_clk_o <= 1'b0;
        end else if (div_sel == ACS_DIVRC) begin
            half_cnt_r <= 4'h0;
            conv_clk_o <= rc_clk_i;
        end else if (half_cnt_r >= half_lim) begin
            half_cnt_r <= 4'h0;
            conv_clk_o <= !conv_clk_o;
        end else begin
            half_cnt_r <= half_cnt_r + 4'h1;
        end
    end

    // result capture with right or left justification
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_r <= 16'h0000;
        end else if (busy && conv_done_i && conv_en) begin
            if (ctrl_sec_r[ACS_SEC_JUST_BIT]) begin
                result_r <= 16'(conv_result_i);
            end else begin
                result_r <= {conv_result_i, (16 - RES_W)'(0)};
            end
        end
    end

    // interrupt status: sticky, a new event wins over a clear
    logic [ACS_IRQ_W-1:0] irq_set;
    logic [ACS_IRQ_W-1:0] irq_clr;
    assign irq_set[ACS_IRQ_DONE_BIT]   = busy && conv_done_i && conv_en;
    assign irq_set[ACS_IRQ_REFUSE_BIT] = start_refused;
    assign irq_clr = wr_iclr ? hwdata_i[ACS_IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // interrupt enable register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_en_r <= '0;
        end else if (wr_ien) begin
            irq_en_r <= hwdata_i[ACS_IRQ_W-1:0];
        end
    end

    // level interrupt output
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_en_r);
        end
    end

endmodule

`default_nettype wire

// File: sim/acs_adc_ctrl_sva.sv
// acs_adc_ctrl_sva: port level checks of the converter control block
// assumes it is bound onto acs_adc_ctrl; one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module acs_adc_ctrl_sva
    import acs_pkg::*;
#(
    parameter int NPINS = 14                    // analog capable pins
) (
    input wire logic             sys_clk_i,           // system clock
    input wire logic             reset_n_i,           // async reset
    input wire logic             hreadyout_o,         // slave ready
    input wire logic             hresp_o,             // response
    input wire logic             conv_enable_o,       // core enabled
    input wire logic             conv_start_o,        // start pulse
    input wire logic             conv_clk_o,          // conv clock
    input wire logic [3:0]       input_channel_sel_o, // channel code
    input wire logic [NPINS-1:0] chan_onehot_o,       // mux select
    input wire logic             chan_comparator_voltage_ref_o,        // comparator_voltage_ref picked
    input wire logic             chan_fixref_o        // fixed ref picked
);
    // every check runs on the system clock, idle while in reset
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_READY: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    AST_START_EN: assert property (conv_start_o |-> conv_enable_o)
        else $error("start issued while converter disabled");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    AST_MUX_ONE: assert property ($onehot0(chan_onehot_o))
        else $error("more than one input channel selected");
    // settled codes need two cycles so a registered decode may lag one
    AST_MUX_CODE: assert property (
        (conv_enable_o && input_channel_sel_o < NPINS) [*2] |->
        chan_onehot_o == (NPINS'(1) << input_channel_sel_o) &&
        !chan_comparator_voltage_ref_o && !chan_fixref_o)
        else $error("input channel decode wrong");
    AST_COMPARATOR_VOLTAGE_REF: assert property (
        (conv_enable_o && input_channel_sel_o == ACS_CHS_COMPARATOR_VOLTAGE_REF) [*2] |->
        chan_comparator_voltage_ref_o && !chan_fixref_o && chan_onehot_o == '0)
        else $error("comparator reference not selected");
    AST_FIXREF: assert property (
        (conv_enable_o && input_channel_sel_o == ACS_CHS_FIXREF) [*2] |->
        chan_fixref_o && !chan_comparator_voltage_ref_o && chan_onehot_o == '0)
        else $error("fixed reference not selected");
    AST_IDLE_OFF: assert property ((!conv_enable_o) [*2] |->
        chan_onehot_o == '0 && !chan_comparator_voltage_ref_o && !chan_fixref_o && !conv_clk_o)
        else $error("disabled core not held idle");
endmodule
`default_nettype wire

// File: sim/acs_core_model.sv
// acs_core_model: behavioural converter core and internal rc oscillator
// assumes start arrives as a one-cycle pulse on the system clock
`timescale 1ns/100ps
`default_nettype none
module acs_core_model (
    input  wire logic       clk_i,     // system clock
    input  wire logic       reset_n_i, // async reset, active low
    input  wire logic       start_i,   // start pulse from the block
    input  wire logic [4:0] dly_i,     // cycles from start to done
    input  wire logic [9:0] val_i,     // result to hand back
    output logic            done_o,    // one-cycle done pulse
    output logic      [9:0] res_o,     // result, inverted outside done
    output logic            rc_clk_o,  // rc clock, half period 7 cycles
    output int              starts_o   // starts seen
);
    logic [4:0] cnt_r;
    logic [2:0] rc_r;
    // conversion timer: one done pulse per start after dly_i cycles
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 5'h0;
            done_o <= 1'b0;
            starts_o <= 0;
        end else begin
            done_o <= (cnt_r == 5'h1);
            if (start_i) begin
                cnt_r <= dly_i;
                starts_o <= starts_o + 1;
            end else if (cnt_r != 5'h0) cnt_r <= cnt_r - 5'h1;
        end
    end
    // the result lines carry junk unless done is up
    assign res_o = done_o ? val_i : ~val_i;
    // free running oscillator, toggles every 7 system cycles
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) rc_r <= 3'h0;
        else rc_r <= (rc_r == 3'h6) ? 3'h0 : rc_r + 3'h1;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) rc_clk_o <= 1'b0;
        else if (rc_r == 3'h6) rc_clk_o <= ~rc_clk_o;
    end
endmodule
`default_nettype wire

// File: sim/tb_acs_adc_ctrl.sv
// tb_acs_adc_ctrl: register level tests of the converter control block
// assumes the core model answers each start after dly cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_acs_adc_ctrl
    import acs_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic        hready, hresp, en, start, cclk, comparator_voltage_ref, fixref, irq, rc, done;
    logic [3:0]  sel;
    logic [13:0] pins = 14'h2a5a, onehot, bufen;
    logic [9:0]  res, val = 10'h2c9;
    logic [4:0]  dly = 5'h14;
    int          err_count = 0, compares = 0, starts;
    acs_adc_ctrl u_acs_adc_ctrl (
        .sys_clk_i(clk), .reset_n_i(rst_n), .hsel_i(1'h1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .rc_clk_i(rc),
        .conv_done_i(done), .conv_result_i(res), .conv_enable_o(en),
        .conv_start_o(start), .conv_clk_o(cclk), .input_channel_sel_o(sel),
        .chan_onehot_o(onehot), .chan_comparator_voltage_ref_o(comparator_voltage_ref), .chan_fixref_o(fixref),
        .port_pin_i(pins), .input_buf_en_o(bufen), .irq_o(irq));
    acs_core_model u_acs_core_model (.clk_i(clk), .reset_n_i(rst_n),
        .start_i(start), .dly_i(dly), .val_i(val), .done_o(done),
        .res_o(res), .rc_clk_o(rc), .starts_o(starts));
    always #2.5 clk = ~clk;
    // one ahb-lite single word transfer; read data taken at phase end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= ACS_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                          input string n);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask
    // enables the core with a divider code and times the conv clock
    task automatic per(input logic [1:0] dv, input int e);
        realtime t;
        xfer(1'b1, ACS_OFS_CTRL_PRI, {24'h0, dv, 6'h01});
        // let the new divider take over before timing a whole period
        repeat (2) @(posedge clk);
        @(posedge cclk);
        t = $realtime;
        @(posedge cclk);
        `CHK("conv clock period", e, int'(($realtime - t) / 5.0))
        @(posedge clk);
    endtask
    task automatic results();
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog: the tests need well under 5000 cycles
    initial begin
        #100us;
        err_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_rd(ACS_OFS_CTRL_PRI, 32'h0, "pri reset");
        chk_rd(ACS_OFS_ASEL_LOW, 32'hff, "asel low reset");
        chk_rd(ACS_OFS_ASEL_HIGH, 32'hff, "asel high reset");
        chk_rd(ACS_OFS_PORT_IN, 32'h0, "analog pins read");
        `CHK("buffers off", 14'h0, bufen)
        chk_rd(8'h3c, 32'h0, "unmapped read");
        xfer(1'b1, ACS_OFS_CTRL_PRI, 32'hfc);
        chk_rd(ACS_OFS_CTRL_PRI, 32'hfc, "pri fields");
        xfer(1'b1, ACS_OFS_CTRL_SEC, 32'hff);
        chk_rd(ACS_OFS_CTRL_SEC, {24'h0, ACS_SEC_WMASK}, "sec mask");
        xfer(1'b1, ACS_OFS_ASEL_LOW, 32'h0f);
        xfer(1'b1, ACS_OFS_ASEL_HIGH, 32'h20);
        // buffer enables and gated pins follow the select one edge late
        repeat (2) @(posedge clk);
        `CHK("buffers on", ~14'h200f, bufen)
        chk_rd(ACS_OFS_PORT_IN, {18'h0, pins & ~14'h200f}, "pins");
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, ACS_OFS_CTRL_PRI, {24'h0, 2'h0, 4'(c), 2'h1});
            repeat (2) @(posedge clk);
            `CHK("chan code", 4'(c), sel)
            `CHK("chan mux", (c < 14) ? 14'h1 << c : 14'h0, onehot)
            `CHK("comparator_voltage_ref", c == 14, comparator_voltage_ref)
            `CHK("fixref", c == 15, fixref)
        end
        per(ACS_DIV2, 2);
        per(ACS_DIV8, 8);
        per(ACS_DIV32, 32);
        per(ACS_DIVRC, 14);
        // slow then prompt core, right then left justified result
        xfer(1'b1, ACS_OFS_IRQ_EN, 32'h3);
        xfer(1'b1, ACS_OFS_CTRL_SEC, 32'h80);
        for (int j = 0; j < 2; j++) begin
            xfer(1'b1, ACS_OFS_CTRL_PRI, 32'h03);
            chk_rd(ACS_OFS_CTRL_PRI, 32'h03, "busy");
            for (int k = 0; k < 40 && rd[1] === 1'b1; k++)
                xfer(1'b0, ACS_OFS_CTRL_PRI, 32'h0);
            `CHK("go cleared", 32'h01, rd)
            `CHK("irq on done", 1'b1, irq)
            chk_rd(ACS_OFS_RESULT, {22'h0, val} << (j * 6), "result");
            chk_rd(ACS_OFS_IRQ_STAT, 32'h1, "done status");
            xfer(1'b1, ACS_OFS_IRQ_CLR, 32'h3);
            xfer(1'b1, ACS_OFS_CTRL_SEC, 32'h0);
            dly <= 5'h3;
        end
        xfer(1'b1, ACS_OFS_CTRL_PRI, 32'h02);
        chk_rd(ACS_OFS_IRQ_STAT, 32'h2, "refused status");
        `CHK("starts", 2, starts)
        `CHK("irq on refuse", 1'b1, irq)
        xfer(1'b1, ACS_OFS_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        xfer(1'b1, ACS_OFS_IRQ_CLR, 32'h3);
        chk_rd(ACS_OFS_IRQ_STAT, 32'h0, "status cleared");
        results();
    end
endmodule
bind acs_adc_ctrl acs_adc_ctrl_sva #(.NPINS(NPINS)) u_acs_adc_ctrl_sva (
    .sys_clk_i, .reset_n_i, .hreadyout_o, .hresp_o, .conv_enable_o,
    .conv_start_o, .conv_clk_o, .input_channel_sel_o, .chan_onehot_o,
    .chan_comparator_voltage_ref_o, .chan_fixref_o);
`default_nettype wire
